// *** i2sl_cfg.svh ***
`ifndef I2SL_CFG_SVH
`define I2SL_CFG_SVH

// register byte offsets
`define I2SL_OFF_CTRL  8'h00
`define I2SL_OFF_STAT  8'h04
`define I2SL_OFF_IEN   8'h08
`define I2SL_OFF_ADDR  8'h0C
`define I2SL_OFF_DATA  8'h10

// control field positions
`define I2SL_CTRL_EN   0
`define I2SL_CTRL_GC   1
`define I2SL_CTRL_ACK  2
`define I2SL_CTRL_DIR  3

// status field positions above the five event flags
`define I2SL_STAT_BUSY 5
`define I2SL_STAT_BUS  6

// reset values and fixed addresses (7-bit, no direction bit)
`define I2SL_RST_EN    1'b1
`define I2SL_RST_OWN   7'h1B
`define I2SL_BOOT_ADDR 7'h1A
`define I2SL_GC_ADDR   7'h00
`define I2SL_RST_LINE  2'h3

// bus answers
`define I2SL_RESP_OK   2'h0
`define I2SL_RESP_ERR  2'h2

`endif

// *** i2sl_pkg.sv ***
package i2sl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_RX
    } i2sl_state_t;

    // the start flag sits in bit 0
    typedef struct packed {
        logic nack;
        logic txd;
        logic amatch;
        logic stop;
        logic start;
    } i2sl_flags_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] q;
    } i2sl_sync_t;

    typedef struct packed {
        i2sl_state_t state;
        logic [2:0]  cnt;
        logic [7:0]  shreg;
        logic [7:0]  rxbuf;
        logic        ack_on;
        logic        ack_bit;
        logic        loaded;
        logic        en;
        logic        gc;
        logic        ack_sel;
        logic        dir;
        logic [6:0]  own;
        i2sl_flags_t flags;
        i2sl_flags_t ien;
        i2sl_flags_t irq;
        logic        busy;
        logic        bus_occ;
        logic        scl_p;
        logic        sda_p;
        logic        sda_oe;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } i2sl_st_t;

endpackage

// *** i2sl_sync.sv ***
`timescale 1ns/1ps
`include "i2sl_cfg.svh"

module i2sl_sync
    import i2sl_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       clock_en,
    // lines, bit 0 clock line, bit 1 data line
    input  wire logic [1:0] line_in,
    output logic      [1:0] line_out
);

    i2sl_sync_t st;
    i2sl_sync_t nxt;

    // first stage feeds only the second; a change needs two agreeing taps
    always_comb begin
        nxt    = st;
        nxt.s1 = line_in;
        nxt.s2 = st.s1;
        nxt.s3 = st.s2;
        for (int i = 0; i < 2; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                nxt.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st <= {4{`I2SL_RST_LINE}};
        end else if (clock_en) begin
            st <= nxt;
        end
    end

    assign line_out = st.q;

endmodule

// *** i2sl_top.sv ***
`timescale 1ns/1ps
`include "i2sl_cfg.svh"

module i2sl_top
    import i2sl_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // clock, reset, enable
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    input  wire logic              CLOCK_EN,
    // two-wire bus pins
    input  wire logic              SCL_I,
    input  wire logic              SDA_I,
    output logic                   SDA_O,
    output logic                   SDA_OE,
    // per-flag requests
    output i2sl_flags_t            IRQ_REQ,
    // register bus write
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // register bus read
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);

    i2sl_st_t   st;
    i2sl_st_t   nxt;
    logic [1:0] line;
    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;
    logic       match;
    logic       wen;
    logic       wr_buf;
    logic [4:0] clr;
    logic [7:0] ar8;

    i2sl_sync u_sync (
        .clock    (CLOCK),
        .reset_n  (RESET_N),
        .clock_en (CLOCK_EN),
        .line_in  ({SDA_I, SCL_I}),
        .line_out (line)
    );

    assign scl      = line[0];
    assign sda      = line[1];
    assign scl_rise = scl & ~st.scl_p;
    assign scl_fall = ~scl & st.scl_p;
    assign start_ev = st.scl_p & scl & st.sda_p & ~sda;
    assign stop_ev  = st.scl_p & scl & ~st.sda_p & sda;
    assign ar8      = 8'(S_AXI_ARADDR);

    // boot address never depends on software
    assign match = (st.shreg[6:0] == st.own)
                 || (st.shreg[6:0] == `I2SL_BOOT_ADDR)
                 || (st.gc && st.shreg[6:0] == `I2SL_GC_ADDR);

    // handshakes stall while the clock enable is low
    assign S_AXI_AWREADY = CLOCK_EN & ~st.aw_got & ~st.bvalid;
    assign S_AXI_WREADY  = CLOCK_EN & ~st.w_got & ~st.bvalid;
    assign S_AXI_ARREADY = CLOCK_EN & ~st.rvalid;

    always_comb begin
        nxt    = st;
        wen    = st.wstrb[0];
        wr_buf = 1'b0;
        clr    = 5'h00;

        // write address and data, either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            nxt.aw_got = 1'b1;
            nxt.awaddr = 8'(S_AXI_AWADDR);
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            nxt.w_got = 1'b1;
            nxt.wdata = S_AXI_WDATA;
            nxt.wstrb = S_AXI_WSTRB;
        end
        if (st.bvalid && S_AXI_BREADY) begin
            nxt.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            nxt.aw_got = 1'b0;
            nxt.w_got  = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp  = `I2SL_RESP_OK;
            if (st.awaddr == `I2SL_OFF_CTRL) begin
                if (wen) begin
                    nxt.en      = st.wdata[`I2SL_CTRL_EN];
                    nxt.gc      = st.wdata[`I2SL_CTRL_GC];
                    nxt.ack_sel = st.wdata[`I2SL_CTRL_ACK];
                end
            end else if (st.awaddr == `I2SL_OFF_STAT) begin
                if (wen) begin
                    clr = st.wdata[4:0];
                end
            end else if (st.awaddr == `I2SL_OFF_IEN) begin
                if (wen) begin
                    nxt.ien = i2sl_flags_t'(st.wdata[4:0]);
                end
            end else if (st.awaddr == `I2SL_OFF_ADDR) begin
                if (wen) begin
                    nxt.own = st.wdata[6:0];
                end
            end else if (st.awaddr == `I2SL_OFF_DATA) begin
                wr_buf = wen;
            end else begin
                nxt.bresp = `I2SL_RESP_ERR;
            end
        end

        // read channel, one outstanding
        if (st.rvalid && S_AXI_RREADY) begin
            nxt.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            nxt.rvalid = 1'b1;
            nxt.rresp  = `I2SL_RESP_OK;
            if (ar8 == `I2SL_OFF_CTRL) begin
                nxt.rdata = {28'h0000000, st.dir, st.ack_sel, st.gc, st.en};
            end else if (ar8 == `I2SL_OFF_STAT) begin
                nxt.rdata = {25'h0000000, st.bus_occ, st.busy, st.flags};
            end else if (ar8 == `I2SL_OFF_IEN) begin
                nxt.rdata = {27'h0000000, st.ien};
            end else if (ar8 == `I2SL_OFF_ADDR) begin
                nxt.rdata = {25'h0000000, st.own};
            end else if (ar8 == `I2SL_OFF_DATA) begin
                nxt.rdata = {24'h000000, st.rxbuf};
            end else begin
                nxt.rdata = 32'h00000000;
                nxt.rresp = `I2SL_RESP_ERR;
            end
        end

        // software clears first so a same-cycle event still lands
        nxt.flags = i2sl_flags_t'(st.flags & ~clr);
        nxt.scl_p = scl;
        nxt.sda_p = sda;

        if (start_ev) begin
            nxt.flags.start = 1'b1;
            nxt.busy        = 1'b1;
            nxt.bus_occ     = 1'b1;
            nxt.cnt         = 3'h0;
            nxt.ack_on      = 1'b0;
            nxt.loaded      = 1'b0;
            nxt.sda_oe      = 1'b0;
            nxt.state       = st.en ? ST_ADDR : ST_IDLE;
        end else if (stop_ev) begin
            nxt.flags.stop = 1'b1;
            nxt.bus_occ    = 1'b0;
            nxt.busy       = 1'b0;
            nxt.loaded     = 1'b0;
            nxt.sda_oe     = 1'b0;
            nxt.state      = ST_IDLE;
        end else begin
            case (st.state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        nxt.shreg = {st.shreg[6:0], sda};
                        nxt.cnt   = st.cnt + 3'h1;
                        if (st.cnt == 3'h7) begin
                            nxt.busy = 1'b0;
                            if (match) begin
                                nxt.dir          = sda;
                                nxt.flags.amatch = 1'b1;
                                nxt.ack_on       = 1'b0;
                                nxt.state        = ST_ACK;
                            end else begin
                                nxt.state = ST_IDLE;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!st.ack_on) begin
                            nxt.ack_on = 1'b1;
                            nxt.sda_oe = ~st.ack_sel;
                        end else begin
                            nxt.ack_on = 1'b0;
                            nxt.busy   = 1'b0;
                            nxt.sda_oe = 1'b0;
                            nxt.cnt    = 3'h0;
                            nxt.state  = st.dir ? ST_TX : ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (wr_buf && !st.busy) begin
                        nxt.shreg  = st.wdata[7:0];
                        nxt.busy   = 1'b1;
                        nxt.loaded = 1'b1;
                        nxt.cnt    = 3'h0;
                        nxt.sda_oe = ~st.wdata[7];
                    end else if (scl_fall && st.loaded) begin
                        nxt.cnt = st.cnt + 3'h1;
                        if (st.cnt == 3'h7) begin
                            nxt.sda_oe = 1'b0;
                            nxt.loaded = 1'b0;
                            nxt.state  = ST_TX_ACK;
                        end else begin
                            nxt.shreg  = {st.shreg[6:0], 1'b0};
                            nxt.sda_oe = ~st.shreg[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nxt.ack_bit    = sda;
                        nxt.flags.nack = sda;
                        nxt.flags.txd  = 1'b1;
                        nxt.busy       = 1'b0;
                    end else if (scl_fall) begin
                        nxt.cnt   = 3'h0;
                        nxt.state = st.ack_bit ? ST_IDLE : ST_TX;
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        if (st.cnt == 3'h0) begin
                            nxt.busy = 1'b1;
                        end
                        nxt.shreg = {st.shreg[6:0], sda};
                        nxt.cnt   = st.cnt + 3'h1;
                        if (st.cnt == 3'h7) begin
                            nxt.rxbuf  = {st.shreg[6:0], sda};
                            nxt.ack_on = 1'b0;
                            nxt.state  = ST_ACK;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        nxt.irq = i2sl_flags_t'(nxt.flags & nxt.ien);
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            st     <= '0;
            st.en  <= `I2SL_RST_EN;
            st.own <= `I2SL_RST_OWN;
            {st.sda_p, st.scl_p} <= `I2SL_RST_LINE; // idle bus, no edge
        end else if (CLOCK_EN) begin
            st <= nxt;
        end
    end

    // open drain: only ever pulls low
    assign SDA_O        = 1'b0;
    assign SDA_OE       = st.sda_oe;
    assign IRQ_REQ      = st.irq;
    assign S_AXI_BVALID = st.bvalid;
    assign S_AXI_BRESP  = st.bresp;
    assign S_AXI_RVALID = st.rvalid;
    assign S_AXI_RDATA  = st.rdata;
    assign S_AXI_RRESP  = st.rresp;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N || !CLOCK_EN);

    sequence s_last_addr_bit;
        st.state == ST_ADDR && scl_rise && st.cnt == 3'h7;
    endsequence

    sequence s_tx_load;
        st.state == ST_TX && wr_buf && !st.busy;
    endsequence

    en_reset_a: assert property (@(posedge CLOCK) disable iff (1'b0)
        $rose(RESET_N) |-> st.en && st.own == `I2SL_RST_OWN)
        else $error("enable or address wrong after reset");
    start_flags_a: assert property (
        start_ev |=> st.flags.start && st.busy && st.bus_occ)
        else $error("start did not set flags");
    stop_flags_a: assert property (
        stop_ev |=> st.flags.stop && !st.bus_occ && st.state == ST_IDLE)
        else $error("stop handling wrong");
    addr_hit_a: assert property (
        s_last_addr_bit ##0 match |=> st.state == ST_ACK && st.flags.amatch
            && !st.busy && st.dir == $past(sda))
        else $error("address match handling wrong");
    addr_miss_a: assert property (
        s_last_addr_bit ##0 !match |=> st.state == ST_IDLE && !st.sda_oe)
        else $error("mismatch did not return idle");
    ack_drive_a: assert property (
        st.state == ST_ACK && scl_fall && !st.ack_on
            |=> st.sda_oe == !$past(st.ack_sel) [*1] ##1 st.state == ST_ACK)
        else $error("acknowledge drive wrong");
    rx_enter_a: assert property (
        st.state == ST_ACK && scl_fall && st.ack_on && !st.dir
            |=> st.state == ST_RX && !st.sda_oe)
        else $error("receive entry wrong");
    tx_load_a: assert property (
        s_tx_load |=> st.busy && st.sda_oe == !$past(st.wdata[7]))
        else $error("msb not placed on load");
    busy_ignore_a: assert property (
        st.state == ST_TX && wr_buf && st.busy && !scl_fall
            && !start_ev && !stop_ev |=> $stable(st.shreg))
        else $error("buffer write while busy took effect");
    tx_release_a: assert property (
        st.state == ST_TX && st.loaded && scl_fall && st.cnt == 3'h7
            && !wr_buf |=> !st.sda_oe && st.state == ST_TX_ACK)
        else $error("line not released after eighth bit");
    ack_sample_a: assert property (
        st.state == ST_TX_ACK && scl_rise |=> st.flags.txd && !st.busy
            && st.flags.nack == $past(sda))
        else $error("acknowledge sample wrong");
    nack_idle_a: assert property (
        st.state == ST_TX_ACK && scl_fall && st.ack_bit
            |=> st.state == ST_IDLE && !st.sda_oe)
        else $error("nack did not return idle");
    rx_first_a: assert property (
        st.state == ST_RX && scl_rise && st.cnt == 3'h0
            |=> st.busy && st.shreg[0] == $past(sda))
        else $error("first receive bit wrong");
    irq_gate_a: assert property (
        IRQ_REQ == i2sl_flags_t'(st.flags & st.ien))
        else $error("request not gated by enable");

endmodule

// *** i2sl_host.sv ***
`timescale 1ns/1ps

module i2sl_host (
    // bus lines
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // quarter of the 800 ns bus clock
    localparam int HQ = 200;

    // idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // data moves only while scl is low; the low phase is long because
    // the device answers a fall up to five system clocks later
    task automatic bit_x(input logic o, output logic i);
        #HQ sda_pull <= ~o;
        #(2*HQ) scl <= 1'b1;
        #HQ i = sda;
        scl <= 1'b0;
    endtask

    // eight bits msb first, then the acknowledge bit
    task automatic byte_x(input logic [7:0] o, input logic ak,
                          output logic [7:0] i, output logic ai);
        for (int k = 7; k >= 0; k--) begin
            bit_x(o[k], i[k]);
        end
        bit_x(ak, ai);
    endtask

    task automatic start;
        #HQ sda_pull <= 1'b0;
        #HQ scl <= 1'b1;
        #(2*HQ) sda_pull <= 1'b1;
        #(2*HQ) scl <= 1'b0;
    endtask

    // clock is left high so the link stands still between frames
    task automatic stop;
        #HQ sda_pull <= 1'b1;
        #(2*HQ) scl <= 1'b1;
        #(2*HQ) sda_pull <= 1'b0;
        #(3*HQ);
    endtask
endmodule

// *** i2c_slave_addr_and_transmit_test.sv ***
`timescale 1ns/1ps
`include "i2sl_cfg.svh"

module i2c_slave_addr_and_transmit_test
    import i2sl_pkg::*;
;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        clock, reset_n, scl, pull, sda, sda_o, sda_oe, ha;
    logic [7:0]  awaddr, araddr, hb;
    logic [31:0] wdata, rdata, rd;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    i2sl_flags_t irq;
    int          errors, n_compared;

    // open drain wire with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;

    i2sl_top i_i2sl_top (
        .CLOCK(clock), .RESET_N(reset_n), .CLOCK_EN(1'b1),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .IRQ_REQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
    );

    i2sl_host i_i2sl_host (.scl(scl), .sda_pull(pull), .sda(sda));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axw(a, d, rs);
        chk(32'(rs), 32'(`I2SL_RESP_OK));
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        axr(a, rd, rs);
        chk(rd & m, e);
    endtask

    // flags land about five cycles after a pin change
    task automatic settle;
        repeat (8) @(posedge clock);
    endtask

    task automatic bye;
        i_i2sl_host.stop();
        settle();
        wr(`I2SL_OFF_STAT, 32'h1F);
    endtask

    task automatic t_reset;
        rc(`I2SL_OFF_CTRL, ALL, 32'h01);
        rc(`I2SL_OFF_ADDR, ALL, 32'h1B);
        rc(`I2SL_OFF_STAT, ALL, 32'h00);
        axr(8'h14, rd, rs);
        chk(rd, 32'h0);
        chk(32'(rs), 32'(`I2SL_RESP_ERR));
        axw(8'h14, 32'hFF, rs);
        chk(32'(rs), 32'(`I2SL_RESP_ERR));
    endtask

    // only the start event is unmasked
    task automatic t_events;
        wr(`I2SL_OFF_IEN, 32'h01);
        i_i2sl_host.start();
        settle();
        rc(`I2SL_OFF_STAT, ALL, 32'h61);
        chk(32'(irq), 32'h01);
        i_i2sl_host.byte_x(8'h54, 1'b1, hb, ha);
        chk(32'(ha), 32'h1);
        i_i2sl_host.byte_x(8'h36, 1'b1, hb, ha);
        chk(32'(ha), 32'h1);
        i_i2sl_host.stop();
        settle();
        rc(`I2SL_OFF_STAT, 32'h46, 32'h02);
        chk(32'(irq), 32'h01);
        wr(`I2SL_OFF_STAT, 32'h1F);
        rc(`I2SL_OFF_STAT, 32'h1F, 32'h00);
    endtask

    task automatic t_addr(input logic [7:0] ct, input logic [7:0] own,
                          input logic [7:0] ab, input logic ack,
                          input logic am);
        wr(`I2SL_OFF_CTRL, 32'(ct));
        wr(`I2SL_OFF_ADDR, 32'(own));
        i_i2sl_host.start();
        i_i2sl_host.byte_x(ab, 1'b1, hb, ha);
        settle();
        chk(32'(ha), 32'(ack));
        rc(`I2SL_OFF_STAT, 32'h04, 32'({am, 2'b00}));
        rc(`I2SL_OFF_CTRL, 32'h0F, 32'(ct));
        bye();
    endtask

    task automatic t_rx;
        wr(`I2SL_OFF_CTRL, 32'h01);
        wr(`I2SL_OFF_ADDR, 32'h1B);
        i_i2sl_host.start();
        i_i2sl_host.byte_x(8'h36, 1'b1, hb, ha);
        i_i2sl_host.byte_x(8'hA5, 1'b1, hb, ha);
        settle();
        rc(`I2SL_OFF_DATA, 32'hFF, 32'hA5);
        bye();
    endtask

    task automatic t_tx;
        wr(`I2SL_OFF_IEN, 32'h1F);
        i_i2sl_host.start();
        i_i2sl_host.byte_x(8'h37, 1'b1, hb, ha);
        settle();
        chk(32'(ha), 32'h0);
        rc(`I2SL_OFF_CTRL, 32'h0F, 32'h09);
        rc(`I2SL_OFF_STAT, 32'h24, 32'h04);
        wr(`I2SL_OFF_STAT, 32'h1F);
        wr(`I2SL_OFF_DATA, 32'hC3);
        wr(`I2SL_OFF_DATA, 32'hFF);
        rc(`I2SL_OFF_STAT, 32'h20, 32'h20);
        i_i2sl_host.byte_x(8'hFF, 1'b0, hb, ha);
        settle();
        chk(32'(hb), 32'hC3);
        rc(`I2SL_OFF_STAT, 32'h38, 32'h08);
        chk(32'(irq), 32'h08);
        wr(`I2SL_OFF_STAT, 32'h1F);
        wr(`I2SL_OFF_DATA, 32'h5A);
        i_i2sl_host.byte_x(8'hFF, 1'b1, hb, ha);
        settle();
        chk(32'(hb), 32'h5A);
        chk(32'(ha), 32'h1);
        rc(`I2SL_OFF_STAT, 32'h38, 32'h18);
        i_i2sl_host.byte_x(8'hFF, 1'b0, hb, ha);
        chk(32'(hb), 32'hFF);
        bye();
        wr(`I2SL_OFF_IEN, 32'h00);
    endtask

    // a hang ends the run well past the expected run of under two hundred microseconds
    initial begin
        #3000000;
        errors++;
        final_report();
    end

    initial begin
        reset_n = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_reset();
        t_events();
        t_addr(8'h01, 8'h1B, 8'h36, 1'b0, 1'b1);
        t_addr(8'h01, 8'h1B, 8'h34, 1'b0, 1'b1);
        t_addr(8'h01, 8'h1B, 8'h00, 1'b1, 1'b0);
        t_addr(8'h03, 8'h1B, 8'h00, 1'b0, 1'b1);
        t_addr(8'h05, 8'h1B, 8'h36, 1'b1, 1'b1);
        t_addr(8'h01, 8'h22, 8'h44, 1'b0, 1'b1);
        t_addr(8'h01, 8'h22, 8'h36, 1'b1, 1'b0);
        t_rx();
        t_tx();
        final_report();
    end
endmodule
